// ==== pkg/oc_pkg.sv ====
// Constants and types shared by the over-current fault response block
package oc_pkg;

  // ----------------------------------------------------------------
  // Command codes of the configuration registers
  // ----------------------------------------------------------------
  localparam logic [7:0]  CMD_OC_THRESHOLD = 8'h46;
  localparam logic [7:0]  CMD_OC_ACTION    = 8'h47;
  localparam logic [7:0]  CMD_TIME_UNIT    = 8'hD2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] THRESHOLD_RST    = 16'h7BFF;  // Largest positive Linear value
  localparam logic [7:0]  ACTION_RST       = 8'h00;
  localparam logic [15:0] TIME_UNIT_RST    = 16'h0000;

  // ----------------------------------------------------------------
  // Field positions of the action register
  // ----------------------------------------------------------------
  localparam int ACT_HI   = 7;
  localparam int ACT_LO   = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  localparam int DELAY_HI = 2;
  localparam int DELAY_LO = 0;

  localparam logic [2:0]  RETRY_NONE       = 3'h0;
  localparam logic [2:0]  RETRY_FOREVER    = 3'h7;

  // Linear format: 5-bit exponent over 11-bit mantissa
  localparam int LIN_EXP_HI = 15;
  localparam int LIN_EXP_LO = 11;
  localparam int LIN_MAN_HI = 10;
  localparam logic [5:0]  LIN_BIAS         = 6'h10;

  // ----------------------------------------------------------------
  // Timing: one time-unit step is one base tick
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 1000;
  localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ACT_CONST   = 2'h0,
    ACT_COND    = 2'h1,
    ACT_DELAY   = 2'h2,
    ACT_DISABLE = 2'h3
  } action_type;

  // Gray codes along run -> limit -> wait -> latched
  typedef enum logic [2:0] {
    ST_RUN   = 3'h0,
    ST_LIMIT = 3'h1,
    ST_WAIT  = 3'h3,
    ST_LATCH = 3'h2,
    ST_HOLD  = 3'h6
  } state_type;

endpackage

// ==== src/delay_timer.sv ====
// Power-of-two delay timer scaled by the configured time unit
`timescale 1ns/1ps

module delay_timer #(
  parameter int TICKS = oc_pkg::TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [2:0]  code,
  input  wire logic [15:0] unit,
  output logic             done
);

  typedef struct packed {
    logic        busy;
    logic        done;
    logic [15:0] tick;
    logic [15:0] unit_cnt;
    logic [7:0]  units;
    logic [15:0] unit_len;
    logic [7:0]  target;
  } tmr_type;

  tmr_type q;
  tmr_type d;

  // ----------------------------------------------------------------
  // Counting chain: base tick, time unit, number of units
  // ----------------------------------------------------------------
  // code n gives 2**n units
  always_comb begin
    d      = q;
    d.done = 1'b0;
    if (start) begin
      d.busy     = 1'b1;
      d.tick     = 16'h0000;
      d.unit_cnt = 16'h0000;
      d.units    = 8'h00;
      d.unit_len = unit;                       // Snapshot, so rewrites do not stretch a delay
      d.target   = 8'((9'h001 << code) - 9'h001);
    end else if (q.busy) begin
      d.tick = q.tick + 16'h0001;
      if (q.tick == 16'(TICKS - 1)) begin
        d.tick     = 16'h0000;
        d.unit_cnt = q.unit_cnt + 16'h0001;
        // unit length from the time-unit register
        if (q.unit_cnt == q.unit_len) begin
          d.unit_cnt = 16'h0000;
          d.units    = q.units + 8'h01;
          if (q.units == q.target) begin
            d.busy = 1'b0;
            d.done = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done = q.done;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [31:0] elapsed_q;
  logic [31:0] expect_q;
  always_ff @(posedge clk) begin
    if (start) begin
      elapsed_q <= 32'h0000_0000;
      expect_q  <= (32'h0000_0001 << code) * (32'(unit) + 32'h0000_0001) * 32'(TICKS);
    end else begin
      elapsed_q <= elapsed_q + 32'h0000_0001;
    end
  end

  property p_done_time;
    @(posedge clk) disable iff (rst) q.done |-> elapsed_q == expect_q;
  endproperty
  a_done_time: assert property (p_done_time) else $error("delay length wrong");

  property p_done_pulse;
    @(posedge clk) disable iff (rst) q.done |=> !q.done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse");

endmodule

// ==== src/overcurrent_fault_response.sv ====
// Output over-current fault detection and response sequencer
`timescale 1ns/1ps

module overcurrent_fault_response (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] wr_data,
  input  wire logic [15:0] iout_linear,
  input  wire logic        vout_below_lv,
  input  wire logic        off_cmd,
  input  wire logic        bias_ok,
  input  wire logic        other_fault,
  input  wire logic        fault_clear,
  output logic [15:0]      rd_data,
  output logic             rd_valid,
  output logic             output_enable,
  output logic             current_limit,
  output logic             oc_fault_flag,
  output logic             host_notify,
  output logic [2:0]       retry_count
);

  typedef struct packed {
    oc_pkg::state_type st;
    logic [15:0]       thresh;
    logic [7:0]        action;
    logic [15:0]       unit;
    logic [2:0]        retry_cnt;
    logic              flag;
    logic              notify;
    logic              out_en;
    logic              limit;
    logic [15:0]       rd_data;
    logic              rd_valid;
  } ctl_type;

  ctl_type q;
  ctl_type d;

  logic               oc;
  logic               stop;
  logic               shut;
  logic               tstart;
  logic               tdone;
  oc_pkg::action_type act;
  logic [2:0]         retries;

  // Linear to unsigned fixed point with 16 fraction bits; negatives read as zero
  // Wide enough that the largest exponent cannot wrap the mantissa
  function automatic logic [47:0] lin_fix(input logic [15:0] v);
    logic [5:0] sh;
    sh      = {v[oc_pkg::LIN_EXP_HI], v[oc_pkg::LIN_EXP_HI:oc_pkg::LIN_EXP_LO]} + oc_pkg::LIN_BIAS;
    lin_fix = 48'h0000_0000_0000;
    if (!v[oc_pkg::LIN_MAN_HI]) begin
      lin_fix = {38'h00_0000_0000, v[oc_pkg::LIN_MAN_HI-1:0]} << sh[4:0];
    end
  endfunction

  // ----------------------------------------------------------------
  // Detection and field decode
  // ----------------------------------------------------------------
  // compare in a common scale
  assign oc      = lin_fix(iout_linear) > lin_fix(q.thresh);
  assign act     = oc_pkg::action_type'(q.action[oc_pkg::ACT_HI:oc_pkg::ACT_LO]);
  assign retries = q.action[oc_pkg::RETRY_HI:oc_pkg::RETRY_LO];
  assign stop    = off_cmd | ~bias_ok | other_fault;
  assign shut    = (q.st == oc_pkg::ST_LIMIT) && oc &&
                   ((act == oc_pkg::ACT_COND && vout_below_lv) || (act == oc_pkg::ACT_DELAY && tdone));

  // ----------------------------------------------------------------
  // Registers, response sequencer and restart bookkeeping
  // ----------------------------------------------------------------
  always_comb begin
    d          = q;
    d.notify   = 1'b0;
    d.rd_valid = rd_en;
    tstart     = 1'b0;
    // Register writes and reads by command code
    if (wr_en) begin
      case (cmd_code)
        oc_pkg::CMD_OC_THRESHOLD: d.thresh = wr_data;
        oc_pkg::CMD_OC_ACTION:    d.action = wr_data[7:0];
        oc_pkg::CMD_TIME_UNIT:    d.unit   = wr_data;
        default:                  d.thresh = q.thresh;
      endcase
    end
    case (cmd_code)
      oc_pkg::CMD_OC_THRESHOLD: d.rd_data = q.thresh;
      oc_pkg::CMD_OC_ACTION:    d.rd_data = {8'h00, q.action};
      oc_pkg::CMD_TIME_UNIT:    d.rd_data = q.unit;
      default:                  d.rd_data = 16'h0000;
    endcase
    // clearing starts the attempt count afresh
    if (fault_clear) begin
      d.flag      = 1'b0;
      d.retry_cnt = 3'h0;
    end
    case (q.st)
      oc_pkg::ST_RUN: begin
        d.out_en = 1'b1;
        d.limit  = 1'b0;
        if (oc) begin
          // flag set wins over a clear in the same cycle
          d.flag   = 1'b1;
          d.notify = 1'b1;
          if (act == oc_pkg::ACT_DISABLE) begin
            d.st     = oc_pkg::ST_HOLD;
            d.out_en = 1'b0;
          end else begin
            // delay timer starts on the first detecting cycle
            d.st    = oc_pkg::ST_LIMIT;
            d.limit = 1'b1;
            tstart  = 1'b1;
          end
        end
      end
      oc_pkg::ST_LIMIT: begin
        // constant-current mode never leaves limiting while fault stands
        if (!oc) begin
          d.st    = oc_pkg::ST_RUN;
          d.limit = 1'b0;
        end
      end
      oc_pkg::ST_WAIT: begin
        if (stop) begin
          d.st = oc_pkg::ST_LATCH;
        end else if (tdone) begin
          d.st     = oc_pkg::ST_RUN;
          d.out_en = 1'b1;
        end
      end
      oc_pkg::ST_HOLD: begin
        // resume once the fault is gone
        if (!oc) begin
          d.st     = oc_pkg::ST_RUN;
          d.out_en = 1'b1;
        end
      end
      oc_pkg::ST_LATCH: begin
        d.out_en = 1'b0;
        if (fault_clear) begin
          d.st     = oc_pkg::ST_RUN;
          d.out_en = 1'b1;
        end
      end
      default: begin
        d.st     = oc_pkg::ST_LATCH;
        d.out_en = 1'b0;
      end
    endcase
    // low voltage, delay expired while limiting
    if (shut) begin
      d.limit  = 1'b0;
      d.out_en = 1'b0;
      // count attempts, endless mode never counts
      if (retries != oc_pkg::RETRY_NONE && (retries == oc_pkg::RETRY_FOREVER || q.retry_cnt < retries)) begin
        // retry delay runs from the shutdown
        d.st   = oc_pkg::ST_WAIT;
        tstart = 1'b1;
        if (retries != oc_pkg::RETRY_FOREVER) begin
          d.retry_cnt = q.retry_cnt + 3'h1;
        end
      end else begin
        d.st = oc_pkg::ST_LATCH;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q        <= '0;
      q.st     <= oc_pkg::ST_RUN;
      q.thresh <= oc_pkg::THRESHOLD_RST;
      q.action <= oc_pkg::ACTION_RST;
      q.unit   <= oc_pkg::TIME_UNIT_RST;
      q.out_en <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // delay length from the delay field and time unit
  delay_timer #(
    .TICKS (oc_pkg::TICK_CYCLES)
  ) u_timer (
    .clk   (clk),
    .rst   (rst),
    .start (tstart),
    .code  (q.action[oc_pkg::DELAY_HI:oc_pkg::DELAY_LO]),
    .unit  (q.unit),
    .done  (tdone)
  );

  assign rd_data       = q.rd_data;
  assign rd_valid      = q.rd_valid;
  assign output_enable = q.out_en;
  assign current_limit = q.limit;
  assign oc_fault_flag = q.flag;
  assign host_notify   = q.notify;
  assign retry_count   = q.retry_cnt;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_flag_notify;
    @(posedge clk) disable iff (rst) (q.st == oc_pkg::ST_RUN && oc) |=> (oc_fault_flag && host_notify);
  endproperty
  a_flag_notify: assert property (p_flag_notify) else $error("fault not flagged");

  property p_const_on;
    @(posedge clk) disable iff (rst) (act == oc_pkg::ACT_CONST && q.st == oc_pkg::ST_LIMIT && !wr_en)
      |=> output_enable;
  endproperty
  a_const_on: assert property (p_const_on) else $error("constant mode turned off");

  property p_cond_shut;
    @(posedge clk) disable iff (rst) (q.st == oc_pkg::ST_LIMIT && oc && act == oc_pkg::ACT_COND && vout_below_lv)
      |=> !output_enable && !current_limit;
  endproperty
  a_cond_shut: assert property (p_cond_shut) else $error("no shutdown on low voltage");

  property p_hold;
    @(posedge clk) disable iff (rst) q.st == oc_pkg::ST_HOLD |=> (output_enable == !$past(oc));
  endproperty
  a_hold: assert property (p_hold) else $error("disable mode output wrong");

  property p_no_retry;
    @(posedge clk) disable iff (rst) (shut && retries == oc_pkg::RETRY_NONE) |=> q.st == oc_pkg::ST_LATCH;
  endproperty
  a_no_retry: assert property (p_no_retry) else $error("retried with zero field");

  property p_count_cap;
    @(posedge clk) disable iff (rst) (retries != oc_pkg::RETRY_FOREVER && !wr_en && q.retry_cnt <= retries)
      |=> q.retry_cnt <= $past(retries);
  endproperty
  a_count_cap: assert property (p_count_cap) else $error("too many restarts");

  property p_latched_off;
    @(posedge clk) disable iff (rst) (q.st == oc_pkg::ST_LATCH && !fault_clear)
      |=> !output_enable && q.st == oc_pkg::ST_LATCH;
  endproperty
  a_latched_off: assert property (p_latched_off) else $error("latched output turned on");

  property p_wait_restart;
    @(posedge clk) disable iff (rst) (q.st == oc_pkg::ST_WAIT && tdone && !stop) |=> output_enable;
  endproperty
  a_wait_restart: assert property (p_wait_restart) else $error("no restart at delay end");

  property p_stop;
    @(posedge clk) disable iff (rst) (q.st == oc_pkg::ST_WAIT && stop) |=> q.st == oc_pkg::ST_LATCH;
  endproperty
  a_stop: assert property (p_stop) else $error("restart not abandoned");

  property p_clear_count;
    @(posedge clk) disable iff (rst) (q.st == oc_pkg::ST_LATCH && fault_clear) |=> retry_count == 3'h0;
  endproperty
  a_clear_count: assert property (p_clear_count) else $error("count not zeroed");

  c_limit: cover property (@(posedge clk) disable iff (rst) q.st == oc_pkg::ST_LIMIT);
  c_retry: cover property (@(posedge clk) disable iff (rst) q.st == oc_pkg::ST_WAIT ##1 q.st == oc_pkg::ST_RUN);
  c_latch: cover property (@(posedge clk) disable iff (rst) q.st == oc_pkg::ST_LATCH);
  c_hold:  cover property (@(posedge clk) disable iff (rst) q.st == oc_pkg::ST_HOLD ##1 q.st == oc_pkg::ST_RUN);

endmodule

// ==== dv/pmbus_host_model.sv ====
// Host-side model that drives the register strobes and the off command
`timescale 1ns/1ps

module pmbus_host_model (
  input  wire logic        clk,
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_valid,
  output logic             wr_en,
  output logic             rd_en,
  output logic [7:0]       cmd_code,
  output logic [15:0]      wr_data,
  output logic             off_cmd
);
  // --------------------------------------------------------------
  // Idle levels
  // --------------------------------------------------------------
  initial begin
    wr_en    = 1'b0;
    rd_en    = 1'b0;
    cmd_code = 8'h00;
    wr_data  = 16'h0000;
    off_cmd  = 1'b0;
  end

  // One-cycle write; released lines flip so stale values never match
  task automatic write_reg(input logic [7:0] cmd, input logic [15:0] data);
    @(posedge clk);
    wr_en    <= 1'b1;
    cmd_code <= cmd;
    wr_data  <= data;
    @(posedge clk);
    wr_en    <= 1'b0;
    cmd_code <= ~cmd;
    wr_data  <= ~data;
  endtask

  // Answer taken mid-cycle, where the registered valid pulse has settled
  task automatic read_reg(input logic [7:0] cmd, output logic [15:0] data);
    @(posedge clk);
    rd_en    <= 1'b1;
    cmd_code <= cmd;
    @(posedge clk);
    rd_en    <= 1'b0;
    cmd_code <= ~cmd;
    data = 16'hxxxx;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      if (rd_valid === 1'b1) begin
        data = rd_data;
        break;
      end
    end
  endtask

  task automatic command_off(input logic v);
    @(posedge clk);
    off_cmd <= v;
  endtask
endmodule

// ==== dv/tb.sv ====
// Self-checking bench for the over-current fault response block
`timescale 1ns/1ps

`define CHK(got, exp) begin \
  check_count++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("[FAIL] %0t mismatch got %h expected %h", $time, got, exp); \
  end \
end

module tb;
  logic        clk;
  logic        rst;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  cmd_code;
  logic [15:0] wr_data;
  logic [15:0] iout_linear;
  logic        vout_below_lv;
  logic        off_cmd;
  logic        bias_ok;
  logic        other_fault;
  logic        fault_clear;
  logic [15:0] rd_data;
  logic        rd_valid;
  logic        output_enable;
  logic        current_limit;
  logic        oc_fault_flag;
  logic        host_notify;
  logic [2:0]  retry_count;
  int          bad_count   = 0;
  int          check_count = 0;
  int          cycles      = 0;
  int          notify_seen = 0;

  overcurrent_fault_response uut (
    .clk(clk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .cmd_code(cmd_code),
    .wr_data(wr_data), .iout_linear(iout_linear), .vout_below_lv(vout_below_lv),
    .off_cmd(off_cmd), .bias_ok(bias_ok), .other_fault(other_fault),
    .fault_clear(fault_clear), .rd_data(rd_data), .rd_valid(rd_valid),
    .output_enable(output_enable), .current_limit(current_limit),
    .oc_fault_flag(oc_fault_flag), .host_notify(host_notify), .retry_count(retry_count)
  );

  pmbus_host_model host (
    .clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .wr_en(wr_en),
    .rd_en(rd_en), .cmd_code(cmd_code), .wr_data(wr_data), .off_cmd(off_cmd)
  );

  // --------------------------------------------------------------
  // Clock, notify counter and hang guard
  // --------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // High cycles counted, so a stuck-high notify shows as extra counts
  always @(posedge clk) begin
    if (host_notify === 1'b1) notify_seen <= notify_seen + 1;
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      bad_count++;
      $display("[FAIL] %0t timeout", $time);
      finish_test();
    end
  end

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic drive(input logic [15:0] v);
    @(posedge clk);
    iout_linear <= v;
  endtask

  // Returns cycles until the level is seen, or -1 if never
  task automatic wait_sig(input int which, input logic v, input int lim, output int n);
    n = -1;
    for (int i = 1; i <= lim; i++) begin
      @(negedge clk);
      if ((which == 0 ? output_enable : current_limit) === v) begin
        n = i;
        break;
      end
    end
  endtask

  // Detection and state edges add a few cycles to each delay
  task automatic near(input int n, input int e);
    `CHK(n >= e - 2 && n <= e + 3, 1'b1)
  endtask

  // Current dropped first, since a set wins over the clear pulse
  task automatic clear_fault();
    @(posedge clk);
    iout_linear   <= 16'h0005;
    vout_below_lv <= 1'b0;
    @(posedge clk);
    fault_clear <= 1'b1;
    @(posedge clk);
    fault_clear <= 1'b0;
    @(negedge clk);
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic check_registers();
    logic [15:0] d;
    `CHK(oc_fault_flag, 1'b0)
    host.read_reg(oc_pkg::CMD_OC_THRESHOLD, d);
    `CHK(d, oc_pkg::THRESHOLD_RST)
    host.read_reg(oc_pkg::CMD_OC_ACTION, d);
    `CHK(d, {8'h00, oc_pkg::ACTION_RST})
    host.read_reg(oc_pkg::CMD_TIME_UNIT, d);
    `CHK(d, oc_pkg::TIME_UNIT_RST)
    host.write_reg(8'h99, 16'h1234);
    host.read_reg(8'h99, d);
    `CHK(d, 16'h0000)
    host.write_reg(oc_pkg::CMD_OC_ACTION, 16'hAB2A);
    host.read_reg(oc_pkg::CMD_OC_ACTION, d);
    `CHK(d, 16'h002A)
    host.write_reg(oc_pkg::CMD_OC_THRESHOLD, 16'h000A);
    host.read_reg(oc_pkg::CMD_OC_THRESHOLD, d);
    `CHK(d, 16'h000A)
  endtask

  // Threshold 10 A; 20 x 2^-1 equals it, 6 x 2^1 exceeds it
  task automatic run_ignore();
    int n0;
    host.write_reg(oc_pkg::CMD_OC_ACTION, 16'h0000);
    n0 = notify_seen;
    drive(16'hF814);
    repeat (10) @(negedge clk);
    `CHK(oc_fault_flag, 1'b0)
    drive(16'h0806);
    repeat (3) @(negedge clk);
    `CHK(oc_fault_flag, 1'b1)
    `CHK(notify_seen - n0, 1)
    `CHK(current_limit, 1'b1)
    repeat (300) @(negedge clk);
    `CHK(output_enable, 1'b1)
    clear_fault();
    `CHK(oc_fault_flag, 1'b0)
  endtask

  task automatic run_disable();
    int n;
    host.write_reg(oc_pkg::CMD_OC_ACTION, 16'h00C0);
    drive(16'h000B);
    wait_sig(0, 1'b0, 4, n);
    `CHK(n > 0, 1'b1)
    repeat (50) @(negedge clk);
    `CHK(output_enable, 1'b0)
    drive(16'h0005);
    wait_sig(0, 1'b1, 4, n);
    `CHK(n > 0, 1'b1)
    clear_fault();
  endtask

  task automatic run_conditioned();
    int n;
    host.write_reg(oc_pkg::CMD_OC_ACTION, 16'h0040);
    drive(16'h000B);
    wait_sig(1, 1'b1, 4, n);
    repeat (50) @(negedge clk);
    `CHK(output_enable, 1'b1)
    @(posedge clk);
    vout_below_lv <= 1'b1;
    wait_sig(0, 1'b0, 4, n);
    `CHK(n > 0, 1'b1)
    wait_sig(0, 1'b1, 500, n);
    `CHK(n, -1)
    clear_fault();
    `CHK(output_enable, 1'b1)
  endtask

  // Delay code 1 with unit 0 gives 2 x 100 cycles
  task automatic run_delay_retry();
    int n;
    host.write_reg(oc_pkg::CMD_OC_ACTION, 16'h0091);
    drive(16'h000B);
    wait_sig(1, 1'b1, 4, n);
    wait_sig(0, 1'b0, 1000, n);
    near(n, 200);
    for (int r = 1; r <= 2; r++) begin
      wait_sig(0, 1'b1, 1000, n);
      near(n, 200);
      `CHK(retry_count, 3'(r))
      wait_sig(0, 1'b0, 1000, n);
      near(n, 200);
    end
    wait_sig(0, 1'b1, 800, n);
    `CHK(n, -1)
    `CHK(retry_count, 3'h2)
    clear_fault();
    `CHK(retry_count, 3'h0)
  endtask

  // Unit 1 doubles the base delay; each stop cause tried in turn
  task automatic run_forever();
    int n;
    host.write_reg(oc_pkg::CMD_TIME_UNIT, 16'h0001);
    host.write_reg(oc_pkg::CMD_OC_ACTION, 16'h00B8);
    drive(16'h000B);
    wait_sig(1, 1'b1, 4, n);
    wait_sig(0, 1'b0, 1000, n);
    near(n, 200);
    for (int r = 0; r < 7; r++) begin
      wait_sig(0, 1'b1, 1000, n);
      near(n, 200);
      wait_sig(0, 1'b0, 1000, n);
    end
    `CHK(retry_count, 3'h0)
    for (int c = 0; c < 3; c++) begin
      if (c == 0) begin
        host.command_off(1'b1);
      end else begin
        @(posedge clk);
        bias_ok     <= (c != 1);
        other_fault <= (c == 2);
      end
      wait_sig(0, 1'b1, 600, n);
      `CHK(n, -1)
      host.command_off(1'b0);
      bias_ok     <= 1'b1;
      other_fault <= 1'b0;
      clear_fault();
      `CHK(output_enable, 1'b1)
      drive(16'h000B);
      wait_sig(0, 1'b0, 1000, n);
    end
    clear_fault();
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    rst           = 1'b1;
    iout_linear   = 16'h0000;
    vout_below_lv = 1'b0;
    bias_ok       = 1'b1;
    other_fault   = 1'b0;
    fault_clear   = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check_registers();
    run_ignore();
    run_disable();
    run_conditioned();
    run_delay_retry();
    run_forever();
    finish_test();
  end
endmodule
